// [rtl/ffps_defs.svh]
// constant definitions for the field peaking select block
`ifndef FFPS_DEFS_SVH
`define FFPS_DEFS_SVH
`define FFPS_ADDR_W        4
`define FFPS_OFS_BANK00    4'h0
`define FFPS_OFS_CUTOFF    4'h1
`define FFPS_OFS_STATUS    4'h2
`define FFPS_SERVO_EN_BIT  12
`define FFPS_DPEAK_LSB     0
`define FFPS_APEAK_LSB     4
`define FFPS_DCUT_LSB      0
`define FFPS_ACUT_LSB      8
`define FFPS_BANK00_RST    16'h0000
`define FFPS_CUTOFF_RST    16'h0000
`define FFPS_KMIN_DATA     4'h2
`define FFPS_PEAK_RST      3'h0
`define FFPS_CUT_RST       7'h00
`define FFPS_RDATA_RST     16'h0000
`endif

// [rtl/ffps_pkg.sv]
// types for the field peaking select block
package ffps_pkg;
  typedef struct packed {
    logic       servo_field;
    logic       slim_floor_off;
    logic [2:0] peak_code;
    logic [6:0] cutoff_code;
    logic       data_gain_sel;
    logic       alt_gain_sel;
  } ffps_sel_t;
endpackage : ffps_pkg

// [rtl/ffps_top.sv]
// field select driven peaking, cutoff and gain control steering
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "ffps_defs.svh"
//////////////////////////////////////////////////////////////////////////////
// How it works
// - field pin acts on the filter only when enable set
// - enable and pin high means servo field
// - servo field uses alternate peaking code
// - data field keeps slimming floor active
// - three bit code picks eight levels
// - servo slimming sits one floor step lower
// - pin always steers gain control input
// - deselected gain input is held
// - two seven bit cutoff codes selected
module ffps_top
  import ffps_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic                    field_select_pin,
  input  wire logic [`FFPS_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  output logic      [2:0]              peak_code,
  output logic      [6:0]              cutoff_code,
  output logic                         slim_floor_on,
  output logic                         data_gain_ctrl_input,
  output logic                         alt_field_gain_ctrl_input,
  output logic                         data_gain_hold,
  output logic                         alt_field_gain_hold,
  output logic                         servo_field
);

  //////////////////////////////////////////////////////////////////////////
  // timing seen from outside
  //   pin change      -> outputs move on the third rising edge
  //                      (two sync flops plus the output flop)
  //   register write  -> outputs move on the second rising edge
  //   read strobe     -> reg_rdata valid for exactly the next cycle
  // nothing here filters a pin that flips faster than the sync chain
  // can follow; the controller must hold each field for a few clocks,
  // which real field lengths cover with a wide margin

  //////////////////////////////////////////////////////////////////////////
  // sizes fixed by the register layout; not meant to be overridden
  // since the bit positions in the registers depend on them
  localparam int SYNC_N = 2;     // flops ahead of any logic on the pin
  localparam int PEAK_W = 3;     // eight slimming levels per field
  localparam int CUT_W  = 7;     // up to 128 cutoff steps per field
  localparam int DATA_W = 16;    // register and read data width

  //////////////////////////////////////////////////////////////////////////
  // shared decoding

  // one address compare, used by the write and the read decoder alike,
  // so both always agree on which offset is which
  function automatic logic fn_hit
  (
    input logic [`FFPS_ADDR_W-1:0] addr,
    input logic [`FFPS_ADDR_W-1:0] ofs
  );
    fn_hit = (addr == ofs);
  endfunction : fn_hit

  // field mux for a peaking code; servo field takes the alternate code
  function automatic logic [PEAK_W-1:0] fn_pick_peak
  (
    input logic              servo,
    input logic [PEAK_W-1:0] alt_code,
    input logic [PEAK_W-1:0] data_code
  );
    fn_pick_peak = servo ? alt_code : data_code;
  endfunction : fn_pick_peak

  // same mux for a cutoff code, kept apart so no width is stretched
  function automatic logic [CUT_W-1:0] fn_pick_cut
  (
    input logic             servo,
    input logic [CUT_W-1:0] alt_code,
    input logic [CUT_W-1:0] data_code
  );
    fn_pick_cut = servo ? alt_code : data_code;
  endfunction : fn_pick_cut

  //////////////////////////////////////////////////////////////////////////
  // reset release
  // the pin asserts reset at once; release walks through two flops so
  // every later flop leaves reset on the same clean clock edge
  logic [1:0] rst_sync;
  logic [1:0] next_rst_sync;
  logic       rst_n;

  // shift a one in behind the released pin
  always_comb
  begin
    next_rst_sync = {rst_sync[0], 1'b1};
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= next_rst_sync;
  end

  // internal copy used by every other flop
  assign rst_n = rst_sync[1];

  //////////////////////////////////////////////////////////////////////////
  // field pin synchroniser
  // the controller drives the pin from its own clock, so it may move at
  // any time; a metastable first stage gets a full clock to settle and
  // only the last stage is read, never the first
  logic [SYNC_N-1:0] pin_sync;
  logic [SYNC_N-1:0] next_pin_sync;
  logic              fsel;

  // new pin value enters at stage zero
  always_comb
  begin
    next_pin_sync = {pin_sync[SYNC_N-2:0], field_select_pin};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pin_sync <= {SYNC_N{1'b0}};
    else
      pin_sync <= next_pin_sync;
  end

  // low after reset, so the first field seen is a data field
  assign fsel = pin_sync[SYNC_N-1];

  //////////////////////////////////////////////////////////////////////////
  // control registers
  // offset 0: bit 12 servo enable, [6:4] alt peaking, [2:0] data peaking
  // offset 1: [14:8] alt cutoff, [6:0] data cutoff
  // offset 2: read only, bit 9 servo field, bit 8 synced pin,
  //           [7:1] live cutoff code
  logic [DATA_W-1:0] bank00;
  logic [DATA_W-1:0] cutoff_reg;
  logic [DATA_W-1:0] next_bank00;
  logic [DATA_W-1:0] next_cutoff_reg;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] status_word;
  logic              wr_bank;
  logic              wr_cut;
  ffps_sel_t         sel;

  // write decode; writes to the status offset or a hole fall away
  // a write lands on the edge that samples the strobe
  always_comb
  begin
    wr_bank         = reg_wr && fn_hit(reg_addr, `FFPS_OFS_BANK00);
    wr_cut          = reg_wr && fn_hit(reg_addr, `FFPS_OFS_CUTOFF);
    next_bank00     = bank00;
    next_cutoff_reg = cutoff_reg;
    if (wr_bank)
      next_bank00 = reg_wdata;
    // bits 7 and 15 have no storage and read back as zero
    if (wr_cut)
      next_cutoff_reg = {1'b0, reg_wdata[14:8], 1'b0, reg_wdata[6:0]};
  end

  // live selection as software sees it: field, synced pin, cutoff
  assign status_word = {6'h00, sel.servo_field, fsel,
                        sel.cutoff_code, 1'b0};

  // read decode; data only in the cycle after the strobe, else zero,
  // so a bus that ors several slaves together needs no extra gating
  always_comb
  begin
    next_rdata = `FFPS_RDATA_RST;
    if (reg_rd)
    begin
      if (fn_hit(reg_addr, `FFPS_OFS_BANK00))
        next_rdata = bank00;
      else if (fn_hit(reg_addr, `FFPS_OFS_CUTOFF))
        next_rdata = cutoff_reg;
      else if (fn_hit(reg_addr, `FFPS_OFS_STATUS))
        next_rdata = status_word;
      else
        next_rdata = `FFPS_RDATA_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank00     <= `FFPS_BANK00_RST;
      cutoff_reg <= `FFPS_CUTOFF_RST;
      reg_rdata  <= `FFPS_RDATA_RST;
    end
    else
    begin
      bank00     <= next_bank00;
      cutoff_reg <= next_cutoff_reg;
      reg_rdata  <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // field selection
  // purely combinational; the output flops below add the only latency
  logic servo_en;

  // enable bit gates what the pin may change in the filter
  assign servo_en = bank00[`FFPS_SERVO_EN_BIT];

  // servo values need both the enable bit and the synced pin high;
  // any other combination gives the data field codes
  always_comb
  begin
    sel.servo_field    = servo_en & fsel;
    // data field keeps the 0.2 floor; servo field drops it to zero
    sel.slim_floor_off = sel.servo_field;
    // code 111 least peaking, 000 most, eight levels
    sel.peak_code      = fn_pick_peak(sel.servo_field,
                           bank00[`FFPS_APEAK_LSB +: PEAK_W],
                           bank00[`FFPS_DPEAK_LSB +: PEAK_W]);
    // two cutoff codes, one per field
    sel.cutoff_code    = fn_pick_cut(sel.servo_field,
                           cutoff_reg[`FFPS_ACUT_LSB +: CUT_W],
                           cutoff_reg[`FFPS_DCUT_LSB +: CUT_W]);
    // gain steering ignores the enable bit
    sel.data_gain_sel  = ~fsel;
    sel.alt_gain_sel   = fsel;
  end

  //////////////////////////////////////////////////////////////////////////
  // output stage
  // every output leaves from a flop so the filter and gain pins never
  // see a decode glitch while the pin or a register changes; the cost
  // is one clock of extra delay on every path
  logic [PEAK_W-1:0] next_peak_code;
  logic [CUT_W-1:0]  next_cutoff_code;
  logic              next_slim_floor_on;
  logic              next_data_gain_ctrl_input;
  logic              next_alt_field_gain_ctrl_input;
  logic              next_data_gain_hold;
  logic              next_alt_field_gain_hold;
  logic              next_servo_field;

  // next output values from the live selection
  // the hold of each gain input is the inverse of its select, so one
  // field always adapts while the other keeps its remembered level
  always_comb
  begin
    next_peak_code                 = sel.peak_code;
    next_cutoff_code               = sel.cutoff_code;
    next_slim_floor_on             = ~sel.slim_floor_off;
    next_data_gain_ctrl_input      = sel.data_gain_sel;
    next_alt_field_gain_ctrl_input = sel.alt_gain_sel;
    // unselected input keeps its remembered gain
    next_data_gain_hold            = ~sel.data_gain_sel;
    next_alt_field_gain_hold       = ~sel.alt_gain_sel;
    next_servo_field               = sel.servo_field;
  end

  // reset leaves the data field selected and the servo input on hold
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // filter side
      peak_code                 <= `FFPS_PEAK_RST;
      cutoff_code               <= `FFPS_CUT_RST;
      slim_floor_on             <= 1'b1;
      servo_field               <= 1'b0;
      // gain side
      data_gain_ctrl_input      <= 1'b1;
      alt_field_gain_ctrl_input <= 1'b0;
      data_gain_hold            <= 1'b0;
      alt_field_gain_hold       <= 1'b1;
    end
    else
    begin
      // filter side
      peak_code                 <= next_peak_code;
      cutoff_code               <= next_cutoff_code;
      slim_floor_on             <= next_slim_floor_on;
      servo_field               <= next_servo_field;
      // gain side
      data_gain_ctrl_input      <= next_data_gain_ctrl_input;
      alt_field_gain_ctrl_input <= next_alt_field_gain_ctrl_input;
      data_gain_hold            <= next_data_gain_hold;
      alt_field_gain_hold       <= next_alt_field_gain_hold;
    end
  end

endmodule : ffps_top
`default_nettype wire

// [tb/ffps_ctl.sv]
// disk controller model driving the field pin
`timescale 1ns/100ps
`default_nettype none
module ffps_ctl (
  input  wire logic clk_sys,
  input  wire logic want,
  output var logic  field_select_pin = 1'b0
);
  // pin moves just after an edge, like a clocked controller output
  always @(posedge clk_sys)
    field_select_pin <= want;
endmodule : ffps_ctl
`default_nettype wire

// [tb/ffps_chk.sv]
// port assertions for the field peaking select block
`timescale 1ns/100ps
`default_nettype none
module ffps_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        field_select_pin,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        slim_floor_on,
  input wire logic        data_gain_ctrl_input,
  input wire logic        alt_field_gain_ctrl_input,
  input wire logic        data_gain_hold,
  input wire logic        alt_field_gain_hold,
  input wire logic        servo_field
);
  logic [2:0] up;
  // wait out internal reset release and pin sync before judging
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (up != 3'h7);
  sequence s_hi; field_select_pin [*5]; endsequence
  sequence s_lo; !field_select_pin [*5]; endsequence
  a_gain_excl: assert property
    (data_gain_ctrl_input != alt_field_gain_ctrl_input)
    else $error("gain select not exclusive");
  a_hold_data: assert property
    (data_gain_hold == alt_field_gain_ctrl_input)
    else $error("data hold wrong");
  a_hold_alt: assert property
    (alt_field_gain_hold == data_gain_ctrl_input)
    else $error("alt hold wrong");
  a_floor_field: assert property (slim_floor_on != servo_field)
    else $error("floor vs field wrong");
  a_pin_hi: assert property (s_hi |-> alt_field_gain_ctrl_input)
    else $error("pin high not steering");
  a_pin_lo: assert property
    (s_lo |-> data_gain_ctrl_input && !servo_field)
    else $error("pin low not data field");
  a_floor_lo: assert property (s_lo |-> slim_floor_on)
    else $error("floor off in data field");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside slot");
endmodule : ffps_chk
bind ffps_top ffps_chk u_chk (.*);
`default_nettype wire

// [tb/filter_field_peaking_select_bench.sv]
// self-checking bench for the field peaking select block
`timescale 1ns/100ps
`default_nettype none
module filter_field_peaking_select_bench;
  logic        clk_sys = 0, rstn = 0, want = 0, reg_wr = 0, reg_rd = 0, e;
  logic        field_select_pin, slim_floor_on, servo_field;
  logic        data_gain_ctrl_input, alt_field_gain_ctrl_input;
  logic        data_gain_hold, alt_field_gain_hold;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, bank, cut, x;
  logic [2:0]  peak_code;
  logic [6:0]  cutoff_code;
  integer      err_total = 0, check_count = 0, seed = 70445, i, r;
  wire  [15:0] got = {peak_code, cutoff_code, slim_floor_on,
    data_gain_ctrl_input, alt_field_gain_ctrl_input, data_gain_hold,
    alt_field_gain_hold, servo_field};
  always #12.5 clk_sys = ~clk_sys;
  ffps_ctl ctl (.clk_sys(clk_sys), .want(want),
    .field_select_pin(field_select_pin));
  ffps_top dut (.*);
  task automatic chk(input string n, input logic [15:0] s, v);
    check_count++;
    if (s !== v)
    begin
      err_total++;
      $display("[ERR] %s exp %h saw %h", n, v, s);
    end
  endtask : chk
  // one bus cycle; strobes stay until the next call replaces them
  task automatic bus(input logic w, q, input logic [3:0] a,
    input logic [15:0] v);
    reg_wr <= w;
    reg_rd <= q;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [15:0] v);
    bus(1'b0, 1'b1, a, 16'h0);
    reg_rd <= 1'b0;
    @(negedge clk_sys) chk("rdata", reg_rdata, v);
    @(posedge clk_sys);
  endtask : rd
  task automatic close_out;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // random field, enable and codes; model worked out per pass
  initial
  begin
    repeat (3) @(posedge clk_sys);
    chk("rst", got, 16'h0032);
    rstn <= 1'b1;
    repeat (3) bus(1'b0, 1'b0, 4'h0, 16'h0);
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      bank = r[15:0] & 16'h1077;
      cut = r[31:16] & 16'h7f7f;
      r = $random(seed);
      want <= r[0];
      e = bank[12] & r[0];
      bus(1'b1, 1'b0, 4'h0, bank);
      bus(1'b1, 1'b0, 4'h1, cut);
      bus(1'b1, 1'b0, 4'h2, ~bank);
      repeat (6) bus(1'b0, 1'b0, 4'h0, 16'h0);
      x = {e ? bank[6:4] : bank[2:0], e ? cut[14:8] : cut[6:0], !e,
        !r[0], r[0], r[0], !r[0], e};
      chk("sel", got, x);
      rd(4'h0, bank);
      rd(4'h1, cut);
      rd(4'h2, {6'h0, e, r[0], x[12:6], 1'b0});
      rd(4'h9, 16'h0);
    end
    close_out;
  end
  // hang guard, far beyond the expected run length
  initial
  begin
    #100000;
    err_total++;
    close_out;
  end
endmodule : filter_field_peaking_select_bench
`default_nettype wire
